// >>> hw/tcs_sensor.v
`timescale 1ns/10ps
`default_nettype none
`include "tcs_consts.vh"

// Contract
// RL1: Each measurement has 9-bit resolution, one step is half a degree.
// RL2: After power-up stay idle, no conversion until commanded.
// RL3: Command 44h starts a temperature conversion.
// RL4: Finished conversion writes two-byte temperature register, then idle.
// RL5: Conversion completes within 750 ms after start.
// RL6: Externally powered: read slots answer 0 while busy, 1 when done; code answers 1 while busy if another command followed the convert.
// RL7: Parasite power: master holds strong pullup, no completion polling.
// RL8: Temperature stored as 16-bit sign-extended two's complement.
// RL9: Sign-extension bits are 0 when positive, 1 when negative.
// RL10: Counts-per-degree register always reads sixteen.
// RL11: Master truncates half-degree bit 0 for extended resolution.
// RL12: Master computes reading minus 0.25 plus count fraction.
// RL13: One-byte upper and lower alarm bytes, kept nonvolatile.
// RL14: Fixed 64-bit identification code held in read-only storage.
// RL15: Data line only driven low, otherwise released.
// RL16: Temperature register holds +85 degrees after power-on.
// RL17: Master enables strong pullup within 10 us of convert command.
// RL18: Residual count updated with every conversion result.
module tcs_sensor #(
  parameter         CONV_CYCLES = `TCS_CONV_CYCLES,
  // Arbitrary identification value
  parameter [63:0]  ID_CODE     = 64'h5A00_0000_0000_01A5
) (
  input  wire                     sys_clk,
  input  wire                     rst,
  input  wire                     cmd_valid,
  input  wire [7:0]               cmd_byte,
  input  wire                     read_slot,
  input  wire                     ext_powered,
  input  wire [`TCS_RAW_W-1:0]    sense_raw,
  input  wire [3:0]               sp_addr,
  input  wire                     sp_rd,
  input  wire                     sp_wr,
  input  wire [7:0]               sp_wdata,
  input  wire                     nv_store,
  input  wire [7:0]               nv_upper_in,
  input  wire [7:0]               nv_lower_in,
  output reg  [7:0]               sp_rdata,
  output reg                      sp_rvalid,
  output wire                     dq_out,
  output wire                     dq_oe,
  output wire                     conv_busy,
  output reg  [7:0]               nv_upper_out,
  output reg  [7:0]               nv_lower_out,
  output reg                      nv_write,
  output wire [63:0]              id_code
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  reg  [1:0]              state_reg;
  reg  [1:0]              state_next;
  reg  [15:0]             temperature_result_reg;
  reg  [7:0]              upper_alarm_trigger_reg;
  reg  [7:0]              lower_alarm_trigger_reg;
  reg  [7:0]              remain_reg;
  reg                     poll_armed_reg;
  wire                    start_cmd;
  wire                    conv_start;
  wire                    core_busy;
  wire                    core_done;
  wire [`TCS_RES_W-1:0]   core_half;
  wire [7:0]              core_remain;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [15:0] sign_extend;
    input [`TCS_RES_W-1:0] v;
    begin
      sign_extend = {{(16-`TCS_RES_W){v[`TCS_RES_SIGN]}}, v};
    end
  endfunction

  function is_alarm_byte;
    input [3:0] a;
    begin
      is_alarm_byte = (a == `TCS_SP_UPPER) || (a == `TCS_SP_LOWER);
    end
  endfunction

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // RL3 convert command
  assign start_cmd  = cmd_valid && (cmd_byte == `TCS_CMD_CONVERT);
  assign conv_start = start_cmd && (state_reg == ST_IDLE) && !core_busy;

  tcs_conv #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_conv (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .start     (conv_start),
    .sense_raw (sense_raw),
    .busy      (core_busy),
    .done      (core_done),
    .half_deg  (core_half),
    .remain    (core_remain)
  );

  // ----------------------------------------------------------------
  // Conversion state machine
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // RL2 idle until commanded
        if (conv_start) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        // RL4 back to idle
        if (core_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign conv_busy = (state_reg == ST_CONV);

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      // RL16 power-on value
      temperature_result_reg <= `TCS_TEMP_RESET;
      remain_reg             <= `TCS_REMAIN_RESET;
    end else if (core_done && state_reg == ST_CONV) begin
      // RL8 sign-extended result
      // RL9 sign bits follow sign
      temperature_result_reg <= sign_extend(core_half);
      // RL18 residual update
      remain_reg             <= core_remain;
    end
  end

  // ----------------------------------------------------------------
  // Alarm bytes and nonvolatile copy
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      // RL13 reload from storage
      upper_alarm_trigger_reg <= nv_upper_in;
      lower_alarm_trigger_reg <= nv_lower_in;
    end else if (sp_wr && is_alarm_byte(sp_addr)) begin
      if (sp_addr == `TCS_SP_UPPER) begin
        upper_alarm_trigger_reg <= sp_wdata;
      end else begin
        lower_alarm_trigger_reg <= sp_wdata;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      nv_upper_out <= 8'h00;
      nv_lower_out <= 8'h00;
      nv_write     <= 1'b0;
    end else begin
      // RL13 keep across power loss
      nv_write <= nv_store;
      if (nv_store) begin
        nv_upper_out <= upper_alarm_trigger_reg;
        nv_lower_out <= lower_alarm_trigger_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Scratchpad read port
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      sp_rdata  <= 8'h00;
      sp_rvalid <= 1'b0;
    end else begin
      sp_rvalid <= sp_rd;
      if (sp_rd) begin
        case (sp_addr)
          `TCS_SP_TEMP_LSB: sp_rdata <= temperature_result_reg[7:0];
          `TCS_SP_TEMP_MSB: sp_rdata <= temperature_result_reg[15:8];
          `TCS_SP_UPPER:    sp_rdata <= upper_alarm_trigger_reg;
          `TCS_SP_LOWER:    sp_rdata <= lower_alarm_trigger_reg;
          `TCS_SP_RSVD0:    sp_rdata <= `TCS_RSVD_VALUE;
          `TCS_SP_RSVD1:    sp_rdata <= `TCS_RSVD_VALUE;
          `TCS_SP_REMAIN:   sp_rdata <= remain_reg;
          // RL10 fixed sixteen
          `TCS_SP_PER_DEG:  sp_rdata <= `TCS_PER_DEG;
          default:          sp_rdata <= `TCS_UNMAPPED_VALUE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Completion polling on read slots
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      poll_armed_reg <= 1'b0;
    end else if (start_cmd) begin
      poll_armed_reg <= 1'b1;
    end else if (cmd_valid) begin
      poll_armed_reg <= 1'b0;
    end
  end

  // RL15 drive low only
  assign dq_out = 1'b0;
  // RL6 zero while busy, only if no other command followed the convert
  // RL7 no polling on parasite power
  assign dq_oe  = read_slot && poll_armed_reg && ext_powered && conv_busy;

  // RL14 read-only code
  assign id_code = ID_CODE;

endmodule // tcs_sensor

`default_nettype wire

// >>> common/tcs_consts.vh
`ifndef TCS_CONSTS_VH
`define TCS_CONSTS_VH

// ----------------------------------------------------------------
// Commands
// ----------------------------------------------------------------
`define TCS_CMD_CONVERT      8'h44

// ----------------------------------------------------------------
// Scratchpad byte offsets
// ----------------------------------------------------------------
`define TCS_SP_TEMP_LSB      4'h0
`define TCS_SP_TEMP_MSB      4'h1
`define TCS_SP_UPPER         4'h2
`define TCS_SP_LOWER         4'h3
`define TCS_SP_RSVD0         4'h4
`define TCS_SP_RSVD1         4'h5
`define TCS_SP_REMAIN        4'h6
`define TCS_SP_PER_DEG       4'h7

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define TCS_RES_W            9
`define TCS_RES_SIGN         8
`define TCS_RAW_W            12
`define TCS_FRAC_BITS        4

// ----------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------
`define TCS_TEMP_RESET       16'h00AA
`define TCS_REMAIN_RESET     8'h0C
`define TCS_PER_DEG          8'h10
`define TCS_REMAIN_BASE      8'h0C
`define TCS_RSVD_VALUE       8'hFF
`define TCS_UNMAPPED_VALUE   8'h00
`define TCS_ROUND_OFFSET     12'h004

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TCS_CLK_KHZ          10000
`define TCS_CONV_MAX_MS      750
`define TCS_CONV_CYCLES      (`TCS_CONV_MAX_MS * `TCS_CLK_KHZ)
`define TCS_CNT_W            23

`endif

// >>> hw/tcs_conv.v
`timescale 1ns/10ps
`default_nettype none
`include "tcs_consts.vh"

module tcs_conv #(
  parameter CONV_CYCLES = `TCS_CONV_CYCLES
) (
  input  wire                     sys_clk,
  input  wire                     rst,
  input  wire                     start,
  input  wire [`TCS_RAW_W-1:0]    sense_raw,
  output reg                      busy,
  output reg                      done,
  output reg  [`TCS_RES_W-1:0]    half_deg,
  output reg  [7:0]               remain
);

  // State register adds one cycle, so the counter stops two short
  localparam [31:0]           LAST_FULL = CONV_CYCLES - 2;
  localparam [`TCS_CNT_W-1:0] LAST      = LAST_FULL[`TCS_CNT_W-1:0];

  reg  [`TCS_CNT_W-1:0] cnt_reg;
  wire [`TCS_RAW_W-1:0] shifted;
  wire [7:0]            frac_off;
  wire [`TCS_RAW_W-1:0] remain_full;

  // ----------------------------------------------------------------
  // Rounding toward nearest half degree
  // ----------------------------------------------------------------
  assign shifted  = sense_raw + `TCS_ROUND_OFFSET;
  assign frac_off    = {{4{1'b0}}, shifted[`TCS_FRAC_BITS-1:0]};
  assign remain_full = `TCS_REMAIN_BASE + `TCS_ROUND_OFFSET - frac_off;

  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_reg  <= {`TCS_CNT_W{1'b0}};
      busy     <= 1'b0;
      done     <= 1'b0;
      half_deg <= {`TCS_RES_W{1'b0}};
      remain   <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy    <= 1'b1;
        cnt_reg <= {`TCS_CNT_W{1'b0}};
      end else if (busy) begin
        // RL5 bounded conversion time
        if (cnt_reg == LAST) begin
          busy     <= 1'b0;
          done     <= 1'b1;
          // RL1 half degree step
          half_deg <= shifted[`TCS_RAW_W-1:`TCS_FRAC_BITS-1];
          // RL18 residual matches result
          remain   <= remain_full[7:0];
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

endmodule // tcs_conv

`default_nettype wire

// >>> tb/tcs_sensor_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcs_consts.vh"
module tcs_sensor_checker #(
  parameter CONV_CYCLES = 8
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_byte,
  input wire logic        read_slot,
  input wire logic        ext_powered,
  input wire logic [3:0]  sp_addr,
  input wire logic        sp_rd,
  input wire logic [7:0]  sp_rdata,
  input wire logic        sp_rvalid,
  input wire logic        dq_out,
  input wire logic        dq_oe,
  input wire logic        conv_busy,
  input wire logic [63:0] id_code
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [23:0] busy_cnt_reg;
  always_ff @(posedge sys_clk) begin
    busy_cnt_reg <= (rst || !conv_busy) ? 24'h0 : busy_cnt_reg + 24'h1;
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  conv_start_a: assert property (
    cmd_valid && cmd_byte == `TCS_CMD_CONVERT && !conv_busy |=> conv_busy)
    else $error("conversion did not start");
  conv_max_a: assert property (
    conv_busy |-> busy_cnt_reg < CONV_CYCLES)
    else $error("conversion too long");
  conv_len_a: assert property (
    $fell(conv_busy) && !$past(rst) |-> busy_cnt_reg == CONV_CYCLES)
    else $error("conversion length wrong");
  per_degree_a: assert property (
    sp_rd && sp_addr == `TCS_SP_PER_DEG |=> sp_rdata == `TCS_PER_DEG)
    else $error("counts per degree wrong");
  sign_ext_a: assert property (
    sp_rd && sp_addr == `TCS_SP_TEMP_MSB |=> sp_rvalid &&
    (sp_rdata == 8'h00 || sp_rdata == 8'hFF))
    else $error("upper byte not sign bits");
  drive_low_a: assert property (dq_oe |-> !dq_out)
    else $error("line driven high");
  poll_busy_a: assert property (
    dq_oe |-> read_slot && ext_powered && conv_busy)
    else $error("line pulled low wrongly");
  poll_done_a: assert property (
    read_slot && !conv_busy |-> !dq_oe)
    else $error("line low after done");
  id_fixed_a: assert property (1 |=> $stable(id_code))
    else $error("identification changed");
  idle_reset_a: assert property ($fell(rst) |-> !conv_busy)
    else $error("busy after reset");
  cover property (cmd_valid && cmd_byte == `TCS_CMD_CONVERT && !conv_busy);
  cover property (dq_oe);
  cover property ($fell(conv_busy));
endmodule // tcs_sensor_checker

bind tcs_sensor tcs_sensor_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_byte(cmd_byte), .read_slot(read_slot), .ext_powered(ext_powered),
  .sp_addr(sp_addr), .sp_rd(sp_rd), .sp_rdata(sp_rdata),
  .sp_rvalid(sp_rvalid), .dq_out(dq_out), .dq_oe(dq_oe),
  .conv_busy(conv_busy), .id_code(id_code));
`default_nettype wire

// >>> tb/tcs_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module tcs_master_model (
  input  wire logic dq_out,
  input  wire logic dq_oe,
  input  wire logic ext_powered,
  input  wire logic conv_busy,
  output logic      dq_line,
  output logic      strong_pu
);
  assign dq_line = dq_oe ? dq_out : 1'b1;
  assign strong_pu = !ext_powered && conv_busy;
endmodule // tcs_master_model
`default_nettype wire

// >>> tb/temp_conversion_sensor_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcs_consts.vh"
module temp_conversion_sensor_test;
  localparam        CONV = 8;
  localparam [63:0] ID   = 64'h0123_4567_89AB_CDEF; // Arbitrary value
  logic        sys_clk = 0, rst = 1, cmd_valid = 0, read_slot = 0;
  logic        ext_powered = 1, sp_rd = 0, sp_wr = 0, nv_store = 0;
  logic [7:0]  cmd_byte = 0, sp_wdata = 0;
  logic [7:0]  nv_upper_in = 8'h4B, nv_lower_in = 8'hF6;
  logic [11:0] sense_raw = 0;
  logic [3:0]  sp_addr = 0;
  logic [7:0]  sp_rdata, nv_upper_out, nv_lower_out;
  logic        sp_rvalid, dq_out, dq_oe, conv_busy, nv_write;
  logic        dq_line, strong_pu;
  logic [63:0] id_code;
  int          errors = 0, samples_checked = 0, cyc = 0;
  tcs_sensor #(.CONV_CYCLES(CONV), .ID_CODE(ID)) u_tcs_sensor (
    .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .read_slot(read_slot), .ext_powered(ext_powered),
    .sense_raw(sense_raw), .sp_addr(sp_addr), .sp_rd(sp_rd),
    .sp_wr(sp_wr), .sp_wdata(sp_wdata), .nv_store(nv_store),
    .nv_upper_in(nv_upper_in), .nv_lower_in(nv_lower_in),
    .sp_rdata(sp_rdata), .sp_rvalid(sp_rvalid), .dq_out(dq_out),
    .dq_oe(dq_oe), .conv_busy(conv_busy), .nv_upper_out(nv_upper_out),
    .nv_lower_out(nv_lower_out), .nv_write(nv_write), .id_code(id_code));
  tcs_master_model u_tcs_master_model (.dq_out(dq_out), .dq_oe(dq_oe),
    .ext_powered(ext_powered), .conv_busy(conv_busy),
    .dq_line(dq_line), .strong_pu(strong_pu));
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk_byte(input string what, input logic [7:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_bit(input string what, input logic exp, got);
    chk_byte(what, {7'h0, exp}, {7'h0, got});
  endtask
  task chk_word(input string what, input logic [15:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Extended reading in sixteenths of a degree
  function automatic logic [15:0] ext_temp(input logic [15:0] t,
                                           input logic [7:0]  rem);
    logic [15:0] whole;
    whole = {t[15], t[15:1]};
    ext_temp = (whole << 4) - 16'h4 + 16'h10 - {8'h0, rem};
  endfunction
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    sp_addr = a;
    sp_rd = 1;
    @(negedge sys_clk);
    sp_rd = 0;
    chk_bit("read valid", 1'b1, sp_rvalid);
    d = sp_rdata;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sp_addr = a;
    sp_wdata = d;
    sp_wr = 1;
    @(negedge sys_clk);
    sp_wr = 0;
  endtask
  task cmd(input logic [7:0] c);
    @(negedge sys_clk);
    cmd_byte = c;
    cmd_valid = 1;
    @(negedge sys_clk);
    cmd_valid = 0;
  endtask
  task convert(input logic [11:0] raw, input logic [7:0] c2, input logic ext);
    logic [12:0] s;
    logic [7:0]  d;
    logic [15:0] t;
    s = {raw[11], raw} + 13'h4;
    sense_raw = raw;
    ext_powered = ext;
    cmd(`TCS_CMD_CONVERT);
    cmd(c2);
    read_slot = 1;
    #1;
    chk_bit("line busy", !(ext && c2 == 8'h44), dq_line);
    chk_bit("strong pullup", !ext, strong_pu);
    for (int n = 0; n < CONV + 4 && conv_busy; n++) @(negedge sys_clk);
    chk_bit("busy", 1'b0, conv_busy);
    chk_bit("line done", 1'b1, dq_line);
    read_slot = 0;
    rd(`TCS_SP_TEMP_LSB, d);
    chk_byte("temp low", s[10:3], d);
    t[7:0] = d;
    rd(`TCS_SP_TEMP_MSB, d);
    chk_byte("temp high", {8{s[11]}}, d);
    t[15:8] = d;
    rd(`TCS_SP_REMAIN, d);
    chk_byte("residual", 8'h10 - {4'h0, s[3:0]}, d);
    chk_word("extended", {{4{raw[11]}}, raw}, ext_temp(t, d));
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0]  d, r1, r2;
    logic [11:0] corner [0:4];
    logic [7:0]  rst_val [0:9];
    corner = '{12'h190, 12'hFF8, 12'h000, 12'h550, 12'hC90};
    rst_val = '{8'hAA, 8'h00, 8'h4B, 8'hF6, 8'hFF, 8'hFF, 8'h0C, 8'h10,
                8'h00, 8'h00};
    void'($urandom(70));
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 0;
    foreach (rst_val[i]) begin
      rd(i[3:0], d);
      chk_byte("reset byte", rst_val[i], d);
    end
    chk_bit("idle", 1'b0, conv_busy);
    $display("test reset values done");
    r1 = 8'($urandom);
    r2 = 8'($urandom);
    wr(`TCS_SP_UPPER, r1);
    wr(`TCS_SP_LOWER, r2);
    wr(`TCS_SP_TEMP_LSB, 8'h55);
    rd(`TCS_SP_UPPER, d);
    chk_byte("upper alarm", r1, d);
    rd(`TCS_SP_LOWER, d);
    chk_byte("lower alarm", r2, d);
    rd(`TCS_SP_TEMP_LSB, d);
    chk_byte("read only temp", 8'hAA, d);
    @(negedge sys_clk);
    nv_store = 1;
    @(negedge sys_clk);
    nv_store = 0;
    chk_bit("nv write", 1'b1, nv_write);
    repeat (2) @(negedge sys_clk);
    chk_bit("nv write end", 1'b0, nv_write);
    chk_byte("stored upper", r1, nv_upper_out);
    chk_byte("stored lower", r2, nv_lower_out);
    chk_bit("id", 1'b1, id_code === ID);
    $display("test alarm bytes done");
    for (int i = 0; i < 13; i++) begin
      convert(i < 5 ? corner[i] : 12'($urandom_range(2880) - 880),
              i[1] ? 8'hBE : `TCS_CMD_CONVERT, !i[0]);
    end
    $display("test conversions done");
    give_verdict();
  end
endmodule // temp_conversion_sensor_test
`default_nettype wire
